// >>> breaker_wear_monitor.sv
// Breaker contact wear monitor with Wishbone register access
//
// Contract
// - Peak search starts only on trip while the breaker reports closed.
// - Keep the largest of the three phase currents during the search.
// - Work on fundamental-frequency magnitudes of the phase currents.
// - Normal end: current below stop level and breaker reports open.
// - Abort after more than one second searching; add no wear then.
// - Wear per operation follows a log-log line through two points.
// - Accumulate wear; raise alarm once total reaches the alarm limit.
// - Accumulated wear is kept in storage that survives power loss; here a register without reset, zero at power-up.
// - Accumulated wear counts 1 kA equivalent operations, readable.
// - A true reset input clears accumulated wear to zero.
// - A remote counter-clear command also clears accumulated wear.
// - While the inhibit input is true all monitoring is suspended.
// - Monitoring runs only when switched on; off by default.
`timescale 1ns/1ps
module breaker_wear_monitor
  import wear_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = wear_pkg::SEARCH_LIMIT_CYCLES
) (
  input  wire logic        clk_i,               // 20 MHz clock
  input  wire logic        rst_i,               // Synchronous reset
  input  wire logic        wb_cyc_i,            // Bus cycle
  input  wire logic        wb_stb_i,            // Strobe
  input  wire logic        wb_we_i,             // Write enable
  input  wire logic [7:0]  wb_adr_i,            // Byte address
  input  wire logic [3:0]  wb_sel_i,            // Byte enables
  input  wire logic [31:0] wb_dat_i,            // Write data
  output logic [31:0]      wb_dat_o,            // Read data
  output logic             wb_ack_o,            // Acknowledge
  input  wire logic [15:0] phase_l1_i,          // L1 magnitude, 10 A
  input  wire logic [15:0] phase_l2_i,          // L2 magnitude, 10 A
  input  wire logic [15:0] phase_l3_i,          // L3 magnitude, 10 A
  input  wire logic        trip_i,              // Trip command
  input  wire logic        breaker_closed_in_i, // Breaker closed
  input  wire logic        breaker_open_in_i,   // Breaker open
  input  wire logic        inhibit_input_i,     // Inhibit monitoring
  input  wire logic        wear_reset_i,        // Clear accumulated wear
  output logic             alarm_o,             // Wear limit reached
  output logic             irq_o                // Interrupt level
);
  import wear_pkg::*;

  // ==================================================================
  // Log2 in Q8.8 by leading one plus linear mantissa
  function automatic logic signed [15:0] log2_q8(input logic [31:0] x);
    logic [4:0]  p;
    logic [31:0] n;
    p = '0;
    for (int b = 0; b < 32; b++) begin
      if (x[b]) p = 5'(b);
    end
    n = x << (5'd31 - p);
    return {3'b000, p, n[30:23]};
  endfunction

  // ==================================================================
  // Registers
  mon_state_t           state_reg, state_next;
  logic                 ack_reg, ack_next;
  logic [31:0]          rdata_reg, rdata_next;
  logic                 on_reg, on_next;
  logic [16:0]          ops1_reg, ops1_next;
  logic [16:0]          opsr_reg, opsr_next;
  logic [16:0]          lim_reg, lim_next;
  logic [15:0]          rated_reg, rated_next;
  logic [15:0]          stop_reg, stop_next;
  logic [15:0]          peak_reg, peak_next;
  logic [TIMER_W-1:0]   tmr_reg, tmr_next;
  logic [EV_W-1:0]      stat_reg, stat_next;
  logic [EV_W-1:0]      mask_reg, mask_next;
  logic                 alarm_reg, alarm_next;
  logic                 irq_reg, irq_next;
  logic [31:0]          wear_reg = '0;
  logic [31:0]          wear_next;

  logic                 wr_en, clr_cmd, div_start, div_done;
  logic [15:0]          max_now;
  logic [23:0]          quot;
  logic [23:0]          dividend;
  logic [15:0]          divisor;
  logic [31:0]          wear_add;
  logic                 alarm_cond;
  logic [EV_W-1:0]      events;

  // Largest fundamental magnitude this cycle
  always_comb begin
    max_now = phase_l1_i;
    if (phase_l2_i > max_now) max_now = phase_l2_i;
    if (phase_l3_i > max_now) max_now = phase_l3_i;
  end

  // ==================================================================
  // Exponent k as fixed-point quotient of two log differences
  always_comb begin
    logic signed [15:0] l1, lr, li;
    l1 = log2_q8({15'd0, ops1_reg});
    lr = log2_q8({15'd0, opsr_reg});
    li = log2_q8({16'd0, rated_reg}) - LOG2_100_Q8;
    dividend = (l1 > lr) ? {16'(l1 - lr), 8'h00} : '0;
    divisor  = (li > 16'sd0) ? 16'(li) : 16'h0001;
  end

  wear_divider u_div (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .start_i    (div_start),
    .dividend_i (dividend),
    .divisor_i  (divisor),
    .done_o     (div_done),
    .quot_o     (quot)
  );

  // Wear of one operation: 2 to the power k * log2(peak in kA)
  always_comb begin
    logic signed [15:0] lp;
    logic        [15:0] k16;
    logic signed [32:0] prod;
    logic signed [16:0] ei;
    logic        [31:0] mant;
    lp   = log2_q8({16'd0, peak_reg}) - LOG2_100_Q8;
    k16  = (|quot[23:16]) ? 16'hFFFF : quot[15:0];
    prod = 33'(lp * $signed({1'b0, k16}));
    ei   = prod[32:16];
    mant = {23'd0, 1'b1, prod[15:8]};
    if (ei > EXP_MAX) begin
      wear_add = 32'hFFFF_FFFF;
    end else if (ei < EXP_MIN) begin
      wear_add = '0;
    end else if (ei >= 17'sd0) begin
      wear_add = mant << 5'(ei);
    end else begin
      wear_add = mant >> 5'(-ei);
    end
  end

  // ==================================================================
  // Search sequencer
  always_comb begin
    state_next = state_reg;
    peak_next  = peak_reg;
    tmr_next   = tmr_reg;
    div_start  = 1'b0;
    events     = '0;
    events[EV_ALARM_BIT] = alarm_cond && !alarm_reg;
    if (inhibit_input_i || !on_reg) begin
      state_next = ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (trip_i && breaker_closed_in_i) begin
            state_next = ST_SEARCH;
            peak_next  = max_now;
            tmr_next   = '0;
          end
        end
        ST_SEARCH: begin
          if (max_now > peak_reg) peak_next = max_now;
          tmr_next = tmr_reg + 1'b1;
          if (tmr_reg > TIMER_W'(TIMEOUT_CYCLES)) begin
            state_next = ST_IDLE;
            events[EV_ABORT_BIT] = 1'b1;
          end else if (max_now < stop_reg && breaker_open_in_i) begin
            state_next = ST_DIVIDE;
            div_start  = 1'b1;
          end
        end
        ST_DIVIDE: begin
          if (div_done) state_next = ST_APPLY;
        end
        ST_APPLY: begin
          state_next = ST_IDLE;
          events[EV_DONE_BIT] = 1'b1;
        end
      endcase
    end
  end

  // ==================================================================
  // Accumulated wear, alarm and interrupt
  assign clr_cmd    = wr_en && wb_adr_i == ADDR_CTRL && wb_sel_i[0]
                      && wb_dat_i[CTRL_CLR_BIT];
  assign alarm_cond = wear_reg >= {7'd0, lim_reg, 8'h00};

  always_comb begin
    logic [32:0] sum;
    sum       = {1'b0, wear_reg} + {1'b0, wear_add};
    wear_next = wear_reg;
    if (wear_reset_i || clr_cmd) begin
      wear_next = '0;
    end else if (state_reg == ST_APPLY && !inhibit_input_i && on_reg) begin
      wear_next = sum[32] ? 32'hFFFF_FFFF : sum[31:0];
    end
    alarm_next = alarm_cond;
    stat_next = stat_reg | events;
    if (wr_en && wb_adr_i == ADDR_STATUS && wb_sel_i[0]) begin
      stat_next = (stat_reg & ~wb_dat_i[EV_W-1:0]) | events;
    end
    irq_next = |(stat_reg & mask_reg);
  end

  // ==================================================================
  // Wishbone slave: ack one cycle after strobe, write on ack edge
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;

  always_comb begin
    ack_next   = wb_cyc_i && wb_stb_i && !ack_reg;
    rdata_next = rdata_reg;
    on_next    = on_reg;
    ops1_next  = ops1_reg;
    opsr_next  = opsr_reg;
    lim_next   = lim_reg;
    rated_next = rated_reg;
    stop_next  = stop_reg;
    mask_next  = mask_reg;
    if (wb_cyc_i && wb_stb_i && !ack_reg) begin
      unique case (wb_adr_i)
        ADDR_CTRL:      rdata_next = {31'd0, on_reg};
        ADDR_OPS_1KA:   rdata_next = {15'd0, ops1_reg};
        ADDR_OPS_RATED: rdata_next = {15'd0, opsr_reg};
        ADDR_ALM_LIMIT: rdata_next = {15'd0, lim_reg};
        ADDR_RATED_I:   rdata_next = {16'd0, rated_reg};
        ADDR_STOP_I:    rdata_next = {16'd0, stop_reg};
        ADDR_WEAR:      rdata_next = wear_reg;
        ADDR_PEAK:      rdata_next = {16'd0, peak_reg};
        ADDR_STATUS:    rdata_next = {29'd0, stat_reg};
        ADDR_MASK:      rdata_next = {29'd0, mask_reg};
        ADDR_STATE:     rdata_next = {30'd0,
                                      state_reg != ST_IDLE, alarm_reg};
        default:        rdata_next = '0;
      endcase
    end
    if (wr_en) begin
      unique case (wb_adr_i)
        ADDR_CTRL:      if (wb_sel_i[0]) on_next = wb_dat_i[CTRL_ON_BIT];
        ADDR_OPS_1KA:   if (&wb_sel_i[2:0]) ops1_next = wb_dat_i[16:0];
        ADDR_OPS_RATED: if (&wb_sel_i[2:0]) opsr_next = wb_dat_i[16:0];
        ADDR_ALM_LIMIT: if (&wb_sel_i[2:0]) lim_next = wb_dat_i[16:0];
        ADDR_RATED_I:   if (&wb_sel_i[1:0]) rated_next = wb_dat_i[15:0];
        ADDR_STOP_I:    if (&wb_sel_i[1:0]) stop_next = wb_dat_i[15:0];
        ADDR_MASK:      if (wb_sel_i[0]) mask_next = wb_dat_i[EV_W-1:0];
        default:        ;
      endcase
    end
  end

  // ==================================================================
  // Wear store has no reset so it survives a device reset on rst_i
  always_ff @(posedge clk_i) begin
    wear_reg <= wear_next;
  end

  // Control and status registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      ack_reg   <= 1'b0;
      rdata_reg <= '0;
      on_reg    <= 1'b0;
      ops1_reg  <= OPS_1KA_RST;
      opsr_reg  <= OPS_RATED_RST;
      lim_reg   <= ALM_LIMIT_RST;
      rated_reg <= RATED_I_RST;
      stop_reg  <= STOP_I_RST;
      peak_reg  <= '0;
      tmr_reg   <= '0;
      stat_reg  <= '0;
      mask_reg  <= '0;
      alarm_reg <= 1'b0;
      irq_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
      on_reg    <= on_next;
      ops1_reg  <= ops1_next;
      opsr_reg  <= opsr_next;
      lim_reg   <= lim_next;
      rated_reg <= rated_next;
      stop_reg  <= stop_next;
      peak_reg  <= peak_next;
      tmr_reg   <= tmr_next;
      stat_reg  <= stat_next;
      mask_reg  <= mask_next;
      alarm_reg <= alarm_next;
      irq_reg   <= irq_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign alarm_o  = alarm_reg;
  assign irq_o    = irq_reg;

  // ==================================================================
  // Assertions
  a_start_needs_closed: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(state_reg) == ST_IDLE && state_reg == ST_SEARCH
    |-> $past(trip_i && breaker_closed_in_i))
    else $error("Search started without trip on closed breaker");
  a_peak_never_drops: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == ST_SEARCH && !inhibit_input_i && on_reg
    |=> peak_reg >= $past(peak_reg) && peak_reg >= $past(max_now))
    else $error("Peak lost during search");
  a_normal_end_cond: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(state_reg) == ST_SEARCH && state_reg == ST_DIVIDE
    |-> $past(max_now < stop_reg && breaker_open_in_i))
    else $error("Search ended without low current and open breaker");
  a_abort_no_wear: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == ST_SEARCH && tmr_reg > TIMER_W'(TIMEOUT_CYCLES)
    && on_reg && !inhibit_input_i && !wear_reset_i && !clr_cmd
    |=> state_reg == ST_IDLE && $stable(wear_reg))
    else $error("Timed out search did not abort cleanly");
  a_alarm_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> alarm_o == $past(alarm_cond))
    else $error("Alarm does not follow wear limit");
  a_wear_adds: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == ST_APPLY && on_reg && !inhibit_input_i
    && !wear_reset_i && !clr_cmd
    |=> wear_reg >= $past(wear_reg))
    else $error("Wear sum decreased on an operation");
  a_reset_clears: assert property (@(posedge clk_i)
    wear_reset_i |=> wear_reg == 32'h0000_0000)
    else $error("Reset input did not clear wear");
  a_cmd_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    clr_cmd |=> wear_reg == 32'h0000_0000)
    else $error("Clear command did not clear wear");
  a_inhibit_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    inhibit_input_i || !on_reg |=> state_reg == ST_IDLE)
    else $error("Monitoring active while inhibited or off");

  c_normal_op: cover property (@(posedge clk_i) disable iff (rst_i)
    stat_reg[EV_DONE_BIT]);
  c_abort_op: cover property (@(posedge clk_i) disable iff (rst_i)
    stat_reg[EV_ABORT_BIT]);
  c_alarm_rise: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(alarm_o));

endmodule

// >>> feeder_model.sv
// Behavioural feeder: phase magnitudes and breaker position
`timescale 1ns/1ps
module feeder_model (
  input  wire logic        clk_i,      // Sampling clock
  input  wire logic [15:0] level_i,    // Fault magnitude, 10 A units
  input  wire logic [1:0]  sel_i,      // Phase carrying the fault
  input  wire logic        open_cmd_i, // Breaker told to open
  output logic [15:0]      l1_o,       // L1 magnitude
  output logic [15:0]      l2_o,       // L2 magnitude
  output logic [15:0]      l3_o,       // L3 magnitude
  output logic             closed_o,   // Breaker closed
  output logic             open_o      // Breaker open
);
  logic [15:0] base;

  // ==========================================================
  // Breaker position
  // Closed contact leaves first, open contact follows a cycle later
  initial begin
    closed_o = 1'b1;
    open_o   = 1'b0;
  end
  always @(posedge clk_i) begin
    closed_o <= !open_cmd_i;
    open_o   <= open_cmd_i && !closed_o;
  end

  // ==========================================================
  // Fundamental magnitudes, zero once the arc is gone
  assign base = open_o ? 16'h0000 : level_i;
  assign l1_o = (sel_i == 2'h0) ? base : base >> 2;
  assign l2_o = (sel_i == 2'h1) ? base : base >> 2;
  assign l3_o = (sel_i == 2'h2) ? base : base >> 2;
endmodule

// >>> tb_top.sv
// Self-checking bench for the breaker contact wear monitor
`timescale 1ns/1ps
module tb_top;
  import wear_pkg::*;
  localparam int TO = 200;
  typedef struct packed { logic [7:0] a; logic [31:0] v; } row_t;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, stb, we, trip, inhibit, wreset, open_cmd;
  logic        ack, alarm, irq, closed, opened;
  logic [7:0]  adr;
  logic [31:0] dat, rdat, q;
  logic [15:0] l1, l2, l3, level;
  logic [1:0]  psel;
  logic [3:0]  sel;
  int          n_mismatch = 0;
  int          tests_run = 0;
  row_t        rows [11] = '{
    '{ADDR_CTRL, 32'h0000_0000}, '{ADDR_OPS_1KA, 32'(OPS_1KA_RST)},
    '{ADDR_OPS_RATED, 32'(OPS_RATED_RST)},
    '{ADDR_ALM_LIMIT, 32'(ALM_LIMIT_RST)},
    '{ADDR_RATED_I, 32'(RATED_I_RST)}, '{ADDR_STOP_I, 32'(STOP_I_RST)},
    '{ADDR_WEAR, 32'h0000_0000}, '{ADDR_STATUS, 32'h0000_0000},
    '{ADDR_MASK, 32'h0000_0000}, '{ADDR_STATE, 32'h0000_0000},
    '{8'h30, 32'h0000_0000}};

  // ==========================================================
  // Clock and instances
  always #25 clk_i = ~clk_i;

  breaker_wear_monitor #(.TIMEOUT_CYCLES(TO)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .phase_l1_i(l1), .phase_l2_i(l2),
    .phase_l3_i(l3), .trip_i(trip), .breaker_closed_in_i(closed),
    .breaker_open_in_i(opened), .inhibit_input_i(inhibit),
    .wear_reset_i(wreset), .alarm_o(alarm), .irq_o(irq));

  feeder_model feeder (
    .clk_i(clk_i), .level_i(level), .sel_i(psel), .open_cmd_i(open_cmd),
    .l1_o(l1), .l2_o(l2), .l3_o(l3), .closed_o(closed), .open_o(opened));

  // ==========================================================
  // Shared tasks
  task automatic check(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    if (n >= 20) check("wb_ack", 32'h0000_0001, 32'h0000_0000);
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    dat <= ~d;
  endtask

  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    check(nm, e, q);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Poll the status word until an event bit shows
  task automatic wait_ev(input logic [31:0] m);
    int n;
    n = 0;
    do begin
      bus(1'b0, ADDR_STATUS, 32'h0000_0000);
      n++;
    end while ((q & m) == 32'h0000_0000 && n < 150);
    if ((q & m) == 32'h0000_0000) check("wait_ev", m, q & m);
  endtask

  // One clock of trip command
  task automatic fire;
    @(posedge clk_i);
    trip <= 1'b1;
    @(posedge clk_i);
    trip <= 1'b0;
  endtask

  // Full interruption at one magnitude, breaker recloses after
  task automatic op(input logic [15:0] lvl);
    level <= lvl;
    fire();
    tick(4);
    open_cmd <= 1'b1;
    wait_ev(32'h0000_0001);
    open_cmd <= 1'b0;
    tick(3);
  endtask

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // Watchdog
  initial begin
    #(50 * 20000);
    n_mismatch++;
    conclude();
  end

  // ==========================================================
  // Main sequence
  initial begin
    {cyc, stb, we, trip, inhibit, wreset, open_cmd} = 7'h00;
    adr = 8'h00;
    dat = 32'h0000_0000;
    level = 16'h0000;
    psel = 2'h2;
    sel = 4'hF;
    tick(8);
    rst_i <= 1'b0;
    tick(1);
    check("alarm_irq", 32'h0000_0000, {30'h0, alarm, irq});
    // Reset values and the unmapped word
    foreach (rows[i]) rd("reg", rows[i].a, rows[i].v);
    // Missing byte lanes leave a 16-bit field untouched
    sel <= 4'h1;
    bus(1'b1, ADDR_STOP_I, 32'h0000_0032);
    sel <= 4'hF;
    rd("stop_lanes", ADDR_STOP_I, 32'(STOP_I_RST));
    level <= 16'h0064;
    fire();
    tick(2);
    rd("busy_off", ADDR_STATE, 32'h0000_0000);
    bus(1'b1, ADDR_CTRL, 32'h0000_0001);
    bus(1'b1, ADDR_MASK, 32'h0000_0001);
    inhibit <= 1'b1;
    fire();
    tick(2);
    rd("busy_inhibit", ADDR_STATE, 32'h0000_0000);
    inhibit <= 1'b0;
    open_cmd <= 1'b1;
    tick(3);
    fire();
    tick(2);
    rd("busy_open", ADDR_STATE, 32'h0000_0000);
    open_cmd <= 1'b0;
    tick(3);
    // Peak on L3, then lower on L1, then low while still closed
    fire();
    rd("busy_on", ADDR_STATE, 32'h0000_0002);
    psel <= 2'h0;
    level <= 16'h003C;
    tick(3);
    level <= 16'h0005;
    tick(5);
    rd("busy_closed", ADDR_STATE, 32'h0000_0002);
    open_cmd <= 1'b1;
    wait_ev(32'h0000_0001);
    open_cmd <= 1'b0;
    rd("peak", ADDR_PEAK, 32'h0000_0064);
    rd("wear_1ka", ADDR_WEAR, 32'h0000_0100);
    check("irq_set", 32'h0000_0001, {31'h0, irq});
    bus(1'b1, ADDR_STATUS, 32'h0000_0001);
    tick(3);
    check("irq_clear", 32'h0000_0000, {31'h0, irq});
    // Second operation reaches a limit of two
    bus(1'b1, ADDR_ALM_LIMIT, 32'h0000_0002);
    op(16'h0064);
    tick(2);
    rd("wear_two", ADDR_WEAR, 32'h0000_0200);
    check("alarm_set", 32'h0000_0001, {31'h0, alarm});
    rd("status_alarm", ADDR_STATUS, 32'h0000_0005);
    bus(1'b1, ADDR_STATUS, 32'h0000_0007);
    // Device reset keeps the stored wear
    rst_i <= 1'b1;
    tick(2);
    rst_i <= 1'b0;
    rd("wear_kept", ADDR_WEAR, 32'h0000_0200);
    bus(1'b1, ADDR_CTRL, 32'h0000_0003);
    tick(2);
    rd("wear_cmd_clr", ADDR_WEAR, 32'h0000_0000);
    check("alarm_clear", 32'h0000_0000, {31'h0, alarm});
    // Breaker never opens: search times out
    level <= 16'h0064;
    fire();
    wait_ev(32'h0000_0002);
    rd("status_abort", ADDR_STATUS, 32'h0000_0002);
    rd("wear_abort", ADDR_WEAR, 32'h0000_0000);
    open_cmd <= 1'b1;
    tick(4);
    open_cmd <= 1'b0;
    tick(4);
    op(16'h0064);
    rd("wear_again", ADDR_WEAR, 32'h0000_0100);
    wreset <= 1'b1;
    tick(2);
    wreset <= 1'b0;
    rd("wear_in_clr", ADDR_WEAR, 32'h0000_0000);
    conclude();
  end
endmodule

// >>> wear_divider.sv
// Sequential restoring divider for the wear curve exponent
`timescale 1ns/1ps
module wear_divider (
  input  wire logic        clk_i,      // System clock
  input  wire logic        rst_i,      // Synchronous reset
  input  wire logic        start_i,    // Start pulse
  input  wire logic [23:0] dividend_i, // Numerator
  input  wire logic [15:0] divisor_i,  // Denominator, non-zero
  output logic             done_o,     // Result ready pulse
  output logic [23:0]      quot_o      // Quotient
);
  logic [23:0] quot_reg, quot_next;
  logic [16:0] rem_reg, rem_next;
  logic [4:0]  cnt_reg, cnt_next;
  logic        busy_reg, busy_next;
  logic        done_reg, done_next;

  // One quotient bit per cycle
  always_comb begin
    logic [16:0] trial;
    trial     = '0;
    quot_next = quot_reg;
    rem_next  = rem_reg;
    cnt_next  = cnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (start_i) begin
      quot_next = dividend_i;
      rem_next  = '0;
      cnt_next  = 5'h18;
      busy_next = 1'b1;
    end else if (busy_reg) begin
      trial = {rem_reg[15:0], quot_reg[23]};
      if (trial >= {1'b0, divisor_i}) begin
        rem_next  = trial - {1'b0, divisor_i};
        quot_next = {quot_reg[22:0], 1'b1};
      end else begin
        rem_next  = trial;
        quot_next = {quot_reg[22:0], 1'b0};
      end
      cnt_next = cnt_reg - 5'h01;
      if (cnt_reg == 5'h01) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end
    end
  end

  // State registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      quot_reg <= '0;
      rem_reg  <= '0;
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      quot_reg <= quot_next;
      rem_reg  <= rem_next;
      cnt_reg  <= cnt_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign done_o = done_reg;
  assign quot_o = quot_reg;

endmodule

// >>> wear_pkg.sv
// Constants shared by the breaker contact wear monitor files
package wear_pkg;

  // ==================================================================
  // Timing
  localparam int unsigned CLK_HZ              = 32'h0131_2D00;
  localparam int unsigned SEARCH_LIMIT_S      = 32'h0000_0001;
  localparam int unsigned SEARCH_LIMIT_CYCLES = SEARCH_LIMIT_S * CLK_HZ;
  localparam int unsigned TIMER_W             = 25;

  // ==================================================================
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_OPS_1KA   = 8'h04;
  localparam logic [7:0] ADDR_OPS_RATED = 8'h08;
  localparam logic [7:0] ADDR_ALM_LIMIT = 8'h0C;
  localparam logic [7:0] ADDR_RATED_I   = 8'h10;
  localparam logic [7:0] ADDR_STOP_I    = 8'h14;
  localparam logic [7:0] ADDR_WEAR      = 8'h18;
  localparam logic [7:0] ADDR_PEAK      = 8'h1C;
  localparam logic [7:0] ADDR_STATUS    = 8'h20;
  localparam logic [7:0] ADDR_MASK      = 8'h24;
  localparam logic [7:0] ADDR_STATE     = 8'h28;

  // ==================================================================
  // Field positions
  localparam int CTRL_ON_BIT     = 0;
  localparam int CTRL_CLR_BIT    = 1;
  localparam int EV_DONE_BIT     = 0;
  localparam int EV_ABORT_BIT    = 1;
  localparam int EV_ALARM_BIT    = 2;
  localparam int EV_W            = 3;
  localparam int ST_ALARM_BIT    = 0;
  localparam int ST_SEARCH_BIT   = 1;

  // ==================================================================
  // Reset values (currents in 10 A units)
  localparam logic [16:0] OPS_1KA_RST   = 17'h0_C350;
  localparam logic [16:0] OPS_RATED_RST = 17'h0_0064;
  localparam logic [16:0] ALM_LIMIT_RST = 17'h0_C350;
  localparam logic [15:0] RATED_I_RST   = 16'h03E8;
  localparam logic [15:0] STOP_I_RST    = 16'h000A;

  // ==================================================================
  // Arithmetic constants: log2(100) in Q8.8 converts 10 A units to kA.
  // Same approximation as the log function, so 1 kA maps to exactly zero
  localparam logic signed [15:0] LOG2_100_Q8 = 16'sh0690;
  localparam logic signed [16:0] EXP_MAX     = 17'sh0_0016;
  localparam logic signed [16:0] EXP_MIN     = -17'sh0_0009;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_SEARCH = 4'b0010,
    ST_DIVIDE = 4'b0100,
    ST_APPLY  = 4'b1000
  } mon_state_t;

endpackage
